// ===== core/kwr_key_wakeup_release.sv
/*
  Key wakeup release logic: the dedicated release pin and, in level mode
  only, four enableable key wake pins end deep-sleep; all are checked at entry.
  Assumes the system control logic pulses sleep_request when the
  entry instruction runs and holds release_mode steady; pins are
  asynchronous and are synchronised here. A combinational wake
  request is also provided for use while clk_sys is stopped.
*/
// Operation
// R1 - Four key pin enables, bits 7..4
// R2 - Enables write-only, reset cleared
// R3 - Level mode: enabled low key releases
// R4 - Sleep entered only by system control
// R5 - Entry with pending wake starts warm-up
// R6 - Release pin: high level or rising edge
// R7 - Edge mode: keys disabled or held high
// R8 - Release pin held low for key wake
// R9 - Wake pins set to input first
// R10 - Software checks keys high before entry
// R11 - Wake path separate from port path
// R12 - Enabled key pin not analog input
// R13 - Wake request works without clock
`timescale 1ns/1ps
`default_nettype none

module kwr_key_wakeup_release (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // System control
  input wire logic sleep_request,
  input wire logic release_mode,
  // Pins
  input wire logic [3:0] key_wake_pin,
  input wire logic release_pin,
  // Status and requests
  output logic [3:0] port_key_level,
  output logic deep_sleep,
  output logic warmup_start,
  output logic wake_request_async
);

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  kwr_pkg::kwr_req_type req;
  wire logic hit_enable;
  wire logic hit_status;
  wire logic wr_enable;

  // Bundle the strobes so decode reads one carrier
  assign req = '{addr: reg_addr, wdata: reg_wdata,
                 wr: reg_wr, rd: reg_rd};
  assign hit_enable = (req.addr == kwr_pkg::KEY_WAKE_ENABLE_ADDR);
  assign hit_status = (req.addr == kwr_pkg::WAKE_STATUS_ADDR);
  assign wr_enable = req.wr && hit_enable;

  // ----------------------------------------------------------------
  // Key wake enable register
  // ----------------------------------------------------------------
  logic [3:0] key_wake_enable;

  // Upper nibble only; the low nibble has no storage at all
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      key_wake_enable <= kwr_pkg::ENABLE_RESET; // R2
    else if (wr_enable)
      key_wake_enable <= req.wdata[kwr_pkg::ENABLE_MSB:kwr_pkg::ENABLE_LSB]; // R1
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] key_meta;
  logic [3:0] key_sync;
  logic [3:0] port_meta;
  logic rel_meta;
  logic rel_sync;
  logic rel_prev;

  // Two stages per pin; first stage feeds only the second
  // Reset to pin idle levels, so no false edge or key follows reset
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      key_meta <= kwr_pkg::KEY_IDLE;
      key_sync <= kwr_pkg::KEY_IDLE;
      rel_meta <= kwr_pkg::REL_IDLE;
      rel_sync <= kwr_pkg::REL_IDLE;
      rel_prev <= kwr_pkg::REL_IDLE;
    end
    else
    begin
      key_meta <= key_wake_pin;
      key_sync <= key_meta;
      rel_meta <= release_pin;
      rel_sync <= rel_meta;
      rel_prev <= rel_sync;
    end
  end

  // Own synchroniser for the port read path, so its level may differ
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      port_meta <= kwr_pkg::KEY_IDLE;
      port_key_level <= kwr_pkg::KEY_IDLE;
    end
    else
    begin
      port_meta <= key_wake_pin; // R11
      port_key_level <= port_meta; // R11
    end
  end

  // ----------------------------------------------------------------
  // Wake condition decode
  // ----------------------------------------------------------------
  wire logic key_low_any;
  wire logic rel_rise;
  wire logic entry_blocked;
  wire logic wake_now;

  // Only enabled keys count; a disabled low pin is ignored
  assign key_low_any = |(key_wake_enable & ~key_sync); // R3
  assign rel_rise = rel_sync && !rel_prev; // R6
  // Entry check looks at the release pin level in both modes
  assign entry_blocked = rel_sync || key_low_any; // R5
  // Keys only release in level mode; edge mode relies on them high
  assign wake_now = release_mode ? (rel_sync || key_low_any) // R3 R6
                                 : rel_rise; // R6 R7

  // Clockless path: raw pins, usable with the core clock stopped
  assign wake_request_async = release_pin ||
                              (|(key_wake_enable & ~key_wake_pin)); // R13

  // ----------------------------------------------------------------
  // Sleep sequencer
  // ----------------------------------------------------------------
  kwr_pkg::kwr_state_type state;
  kwr_pkg::kwr_state_type next_state;
  logic next_warmup;

  // Entry only on the system control request; wake pins only exit
  always_comb
  begin
    next_state = state;
    next_warmup = 1'b0;
    case (state)
      kwr_pkg::KWR_RUN:
      begin
        if (sleep_request)
        begin
          if (entry_blocked)
            next_warmup = 1'b1; // R5
          else
            next_state = kwr_pkg::KWR_SLEEP; // R4
        end
      end
      kwr_pkg::KWR_SLEEP:
      begin
        if (wake_now)
        begin
          next_state = kwr_pkg::KWR_RUN; // R3 R6
          next_warmup = 1'b1;
        end
      end
      default:
      begin
        next_state = kwr_pkg::KWR_RUN;
      end
    endcase
  end

  // State and one-cycle warm-up start pulse
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      state <= kwr_pkg::KWR_RUN;
      warmup_start <= 1'b0;
    end
    else
    begin
      state <= next_state;
      warmup_start <= next_warmup;
    end
  end

  assign deep_sleep = (state == kwr_pkg::KWR_SLEEP);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire logic [7:0] status_word;
  wire logic [7:0] next_rdata;

  // Status gives sleep state, release pin and synced key levels
  assign status_word = {key_sync, 2'b00, rel_sync, deep_sleep};
  // Enable register is write-only, so it reads back as zero
  assign next_rdata = (req.rd && hit_status) ? status_word
                                             : kwr_pkg::READ_ZERO; // R2

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      reg_rdata <= kwr_pkg::READ_ZERO;
    else
      reg_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Wake pins may only end sleep; entry is the request's alone
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  chk_enable_write: assert property ( // R1
    wr_enable |=> key_wake_enable == $past(reg_wdata[7:4]))
    else $error("enable bits not stored from write");

  chk_enable_read_zero: assert property ( // R2
    reg_rd && hit_enable |=> reg_rdata == 8'h00)
    else $error("write-only enable read not zero");

  chk_level_release: assert property ( // R3
    deep_sleep && release_mode && key_low_any
      |=> !deep_sleep && warmup_start)
    else $error("enabled low key did not release");

  chk_disabled_ignored: assert property ( // R3
    deep_sleep && release_mode && !rel_sync && !key_low_any
      |=> deep_sleep)
    else $error("sleep left without enabled wake source");

  chk_entry_only_request: assert property ( // R4
    $rose(deep_sleep) |-> $past(sleep_request) && !$past(entry_blocked))
    else $error("sleep entered without clean request");

  chk_keys_no_entry: assert property ( // R4
    !deep_sleep && !sleep_request |=> !deep_sleep)
    else $error("sleep entered with no request");

  // Back-to-back requests are legal, so only a lone one is judged
  chk_entry_abort: assert property ( // R5
    !deep_sleep && sleep_request && entry_blocked ##1 !sleep_request
      |-> !deep_sleep && warmup_start ##1 !warmup_start)
    else $error("blocked entry did not start warm-up");

  chk_warmup_single: assert property ( // R5
    warmup_start && !sleep_request |=> !warmup_start)
    else $error("warm-up start longer than one cycle");

  chk_edge_release: assert property ( // R6
    deep_sleep && !release_mode && rel_rise |=> !deep_sleep)
    else $error("rising edge did not release");

  chk_edge_keys_ignored: assert property ( // R6
    deep_sleep && !release_mode && !rel_rise |=> deep_sleep)
    else $error("edge mode released without edge");

  chk_port_path: assert property ( // R11
    port_key_level == $past(port_meta))
    else $error("port path not a plain second stage");

  chk_async_request: assert property ( // R13
    release_pin |-> wake_request_async)
    else $error("release pin gave no async request");

  chk_async_quiet: assert property ( // R13
    !release_pin && !(|(key_wake_enable & ~key_wake_pin))
      |-> !wake_request_async)
    else $error("async request without wake source");

  chk_wake_async_key: assert property ( // R13
    (|(key_wake_enable & ~key_wake_pin)) |-> wake_request_async)
    else $error("enabled low key gave no async request");

  cov_level_wake: cover property (
    deep_sleep && release_mode ##1 !deep_sleep);
  cov_edge_wake: cover property (
    deep_sleep && !release_mode ##1 !deep_sleep);
  cov_entry_abort: cover property (
    !deep_sleep && sleep_request && entry_blocked);
  cov_enable_write: cover property (wr_enable ##1 sleep_request);
  cov_disabled_low: cover property (
    deep_sleep && release_mode && |(~key_sync & ~key_wake_enable));

endmodule : kwr_key_wakeup_release

`default_nettype wire

// ===== core/kwr_pkg.sv
/*
  Package for the key wakeup release block: register offsets, field
  positions, reset values and the sequencer states.
  Assumes a 12-bit register address space with 8-bit data.
*/
`default_nettype none

package kwr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int KEY_N = 4;
  localparam logic [11:0] KEY_WAKE_ENABLE_ADDR = 12'hF9F;
  localparam logic [11:0] WAKE_STATUS_ADDR = 12'hFA0;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int ENABLE_LSB = 4;
  localparam int ENABLE_MSB = 7;
  localparam logic [3:0] KEY_IDLE = 4'hF;
  localparam logic REL_IDLE = 1'b0;
  localparam int STAT_SLEEP_BIT = 0;
  localparam int STAT_REL_BIT = 1;
  localparam int STAT_KEY_LSB = 4;
  localparam logic [3:0] ENABLE_RESET = 4'h0;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ----------------------------------------------------------------
  // Sequencer states and register-port carrier
  // ----------------------------------------------------------------
  typedef enum logic {
    KWR_RUN,
    KWR_SLEEP
  } kwr_state_type;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } kwr_req_type;

endpackage : kwr_pkg

`default_nettype wire

// ===== test/kwr_key_model.sv
/*
  Far-side model: key switches and the wake source on the release pin.
  Assumes the bench commands which keys are pressed and the pin level.
*/
`timescale 1ns/1ps
`default_nettype none

module kwr_key_model (
  // Commands from the bench
  input wire logic [3:0] key_hold_low,
  input wire logic rel_high,
  // Pins into the block
  output logic [3:0] key_wake_pin,
  output logic release_pin
);
  // Keys idle high by pull-up; only a pressed key pulls low
  assign key_wake_pin = ~key_hold_low;
  // Release pin stays low unless a wake by that pin is wanted
  assign release_pin = rel_high;
endmodule : kwr_key_model

`default_nettype wire

// ===== test/kwr_key_wakeup_release_bench.sv
/*
  Self-checking bench for the key wakeup release block.
  Assumes a 100 MHz clock and the register and sleep timing of the core.
*/
`timescale 1ns/1ps
`default_nettype none

module kwr_key_wakeup_release_bench;
  logic clk_sys, resetn, reg_wr, reg_rd, sleep_request, release_mode;
  logic rel_high, release_pin, deep_sleep, warmup_start, wake_request_async;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_val;
  logic [3:0] key_hold_low, key_wake_pin, port_key_level;
  int err_total, n_checks;

  kwr_key_wakeup_release uut (.clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_request(sleep_request),
    .release_mode(release_mode), .key_wake_pin(key_wake_pin),
    .release_pin(release_pin), .port_key_level(port_key_level),
    .deep_sleep(deep_sleep), .warmup_start(warmup_start),
    .wake_request_async(wake_request_async));
  kwr_key_model keys (.key_hold_low(key_hold_low), .rel_high(rel_high),
    .key_wake_pin(key_wake_pin), .release_pin(release_pin));

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [11:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd

  // Pins need two edges through the synchronisers; three is safe
  task settle;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle

  task enter;
    @(posedge clk_sys);
    sleep_request <= 1'b1;
    @(posedge clk_sys);
    sleep_request <= 1'b0;
    #1;
  endtask : enter

  // Bounded wait for the one-cycle warm-up pulse
  task wake_wait;
    for (int i = 0; i < 10 && warmup_start !== 1'b1; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
    chk({7'h00, warmup_start}, 8'h01);
    chk({7'h00, deep_sleep}, 8'h00);
  endtask : wake_wait

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_regs;
    rd(12'hF9F);
    chk(rd_val, 8'h00);
    wr(12'hF9F, 8'hF5);
    rd(12'hF9F);
    chk(rd_val, 8'h00);
    rd(12'h123);
    chk(rd_val, 8'h00);
    rd(12'hFA0);
    chk(rd_val, 8'hF0);
    @(posedge clk_sys);
    #1 chk(reg_rdata, 8'h00);
  endtask : t_regs

  // Each enable alone; the other, disabled keys held low must not wake
  task t_keys;
    for (int i = 0; i < 4; i++)
    begin
      wr(12'hF9F, 8'h10 << i);
      enter;
      chk({7'h00, deep_sleep}, 8'h01);
      @(posedge clk_sys);
      key_hold_low <= 4'hF ^ (4'h1 << i);
      settle;
      chk({7'h00, deep_sleep}, 8'h01);
      chk({7'h00, wake_request_async}, 8'h00);
      chk({4'h0, port_key_level}, 8'h01 << i);
      @(posedge clk_sys);
      key_hold_low <= 4'hF;
      #1 chk({7'h00, wake_request_async}, 8'h01);
      wake_wait;
      @(posedge clk_sys);
      key_hold_low <= 4'h0;
      settle;
    end
  endtask : t_keys

  // Pending wake at entry turns into an immediate warm-up
  task t_entry;
    wr(12'hF9F, 8'h80);
    key_hold_low <= 4'h8;
    settle;
    enter;
    chk({6'h00, warmup_start, deep_sleep}, 8'h02);
    @(posedge clk_sys);
    key_hold_low <= 4'h1;
    rel_high <= 1'b1;
    settle;
    enter;
    chk({6'h00, warmup_start, deep_sleep}, 8'h02);
    @(posedge clk_sys);
    rel_high <= 1'b0;
    settle;
    enter;
    chk({7'h00, deep_sleep}, 8'h01);
    @(posedge clk_sys);
    rel_high <= 1'b1;
    wake_wait;
    @(posedge clk_sys);
    rel_high <= 1'b0;
    key_hold_low <= 4'h0;
    settle;
  endtask : t_entry

  // Edge mode: only a rising release pin ends the sleep
  task t_edge;
    @(posedge clk_sys);
    release_mode <= 1'b0;
    enter;
    settle;
    chk({7'h00, deep_sleep}, 8'h01);
    @(posedge clk_sys);
    rel_high <= 1'b1;
    wake_wait;
    @(posedge clk_sys);
    rel_high <= 1'b0;
  endtask : t_edge

  // ------------------------------------------------------------
  // Clock, run and verdict
  // ------------------------------------------------------------
  task print_verdict;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Whole run is about 130 cycles; this is over thirty times that
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_total++;
    print_verdict;
  end

  initial
  begin
    {resetn, reg_wr, reg_rd, sleep_request, rel_high} = 5'h00;
    release_mode = 1'b1;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
    key_hold_low = 4'h0;
    err_total = 0;
    n_checks = 0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    settle;
    t_regs;
    t_keys;
    t_entry;
    t_edge;
    print_verdict;
  end
endmodule : kwr_key_wakeup_release_bench

`default_nettype wire
